// *** dram_mode_register_map_tb_top.sv ***
/*
  Self-checking bench for mrm_regs with the host model on the command port.
  Assumes a 10 MHz core_clk and synchronous active-low rstn.
*/
`timescale 1ns/1ns
`default_nettype none
module dram_mode_register_map_tb_top;
  import mrm_pkg::*;
  logic core_clk, rstn, wr_cmd, rd_cmd, rd_valid, op_sel, wr_sel;
  logic ca_flag, lat_cap, ref_cap, zq_done;
  logic [1:0] zq_res;
  mrm_addr_t addr, op_addr;
  mrm_data_t opcode, rd_data, op_data;
  mrm_data_t ro_in [7];
  mrm_addr_t ro_a [7] = '{MAKER_CODE_A, REVISION_CODE_ONE_A, REVISION_CODE_TWO_A,
    WIDTH_DENSITY_TYPE_A, STROBE_OSC_COUNT_LOW_A, STROBE_OSC_COUNT_HIGH_A, REPAIR_RESOURCES_A};
  int n_fail, num_checks;

  mrm_host_model i_host (.core_clk(core_clk), .mode_reg_write_cmd(wr_cmd),
    .mode_reg_read_cmd(rd_cmd), .mr_addr_field(addr), .wr_opcode(opcode),
    .rd_valid(rd_valid), .rd_data(rd_data));

  mrm_regs i_dut (.core_clk(core_clk), .rstn(rstn), .mode_reg_write_cmd(wr_cmd),
    .mode_reg_read_cmd(rd_cmd), .mr_addr_field(addr), .wr_opcode(opcode),
    .rd_valid(rd_valid), .rd_data(rd_data), .ca_term_rank_flag(ca_flag),
    .latency_mode_cap(lat_cap), .refresh_mode_cap(ref_cap), .zq_latch_done(zq_done),
    .zq_selftest_result(zq_res), .maker_code(ro_in[0]), .revision_one(ro_in[1]),
    .revision_two(ro_in[2]), .width_density(ro_in[3]), .osc_count_low(ro_in[4]),
    .osc_count_high(ro_in[5]), .repair_res(ro_in[6]), .op_addr(op_addr),
    .op_data(op_data), .setpoint_operate_select(op_sel), .setpoint_write_select(wr_sel));

  always #50 core_clk = ~core_clk;

  task automatic final_report();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input mrm_data_t e, input mrm_data_t g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic rd_chk(input mrm_addr_t a, input mrm_data_t e);
    mrm_data_t d;
    logic ok;
    i_host.mr_read(a, d, ok);
    chk("rd_valid", 8'h01, {7'h00, ok});
    chk($sformatf("register %h", a), e, d);
  endtask

  // ZQ field empty until a latch, reserved bits low
  task automatic t_info();
    chk("selects", 8'h00, {6'h00, op_sel, wr_sel});
    rd_chk(DEVICE_INFO_A, 8'h83);
    @(posedge core_clk);
    #1;
    zq_done = 1'b1;
    @(posedge core_clk);
    #1;
    zq_done = 1'b0;
    rd_chk(DEVICE_INFO_A, 8'h9B);
    i_host.mr_write(DEVICE_INFO_A, 8'h00);
    rd_chk(DEVICE_INFO_A, 8'h9B);
  endtask

  task automatic t_ro();
    for (int i = 0; i < 7; i++) begin
      rd_chk(ro_a[i], ro_in[i]);
      i_host.mr_write(ro_a[i], ~ro_in[i]);
      rd_chk(ro_a[i], ro_in[i]);
    end
  endtask

  task automatic t_rw();
    i_host.mr_write(REFRESH_AND_TRAINING_A, 8'hA5);
    i_host.mr_write(ROW_HAMMER_CONTROL_A, 8'h5A);
    i_host.mr_write(DATA_BUS_VREF_A, 8'hFF);
    rd_chk(REFRESH_AND_TRAINING_A, 8'hA5);
    rd_chk(ROW_HAMMER_CONTROL_A, 8'h5A);
    rd_chk(DATA_BUS_VREF_A, 8'h7F);
  endtask

  // undefined reads come back as the chosen pattern; ignored writes leave no trace
  task automatic t_hidden();
    i_host.mr_write(DEVICE_FEATURE_ONE_A, 8'h3C);
    rd_chk(DEVICE_FEATURE_ONE_A, UNDEF_DATA);
    i_host.mr_write(TEST_RESERVED_A_A, 8'hFF);
    rd_chk(TEST_RESERVED_A_A, UNDEF_DATA);
    i_host.mr_write(6'h21, 8'hFF);
    rd_chk(6'h21, UNDEF_DATA);
    rd_chk(RESERVED_FUTURE_A_A, UNDEF_DATA);
    rd_chk(REFRESH_AND_TRAINING_A, 8'hA5);
  endtask

  task automatic t_setpoint();
    i_host.mr_write(REGISTER_CONTROL_A, 8'hC0);
    chk("selects", 8'h03, {6'h00, op_sel, wr_sel});
    i_host.mr_write(CMD_BUS_VREF_A, 8'h11);
    i_host.mr_write(REGISTER_CONTROL_A, 8'h80);
    i_host.mr_write(CMD_BUS_VREF_A, 8'h22);
    rd_chk(CMD_BUS_VREF_A, 8'h22);
    chk("op_data", 8'h11, op_data);
    i_host.mr_write(REGISTER_CONTROL_A, 8'h40);
    rd_chk(CMD_BUS_VREF_A, 8'h11);
    chk("op_data", 8'h22, op_data);
  endtask

  task automatic t_reset_mid();
    @(posedge core_clk);
    #1;
    rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    chk("selects", 8'h00, {6'h00, op_sel, wr_sel});
    rd_chk(DEVICE_INFO_A, 8'h83);
  endtask

  initial begin
    #2000000;
    n_fail++;
    final_report();
  end

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    {ca_flag, lat_cap, ref_cap, zq_done} = 4'hE;
    zq_res = 2'h3;
    op_addr = CMD_BUS_VREF_A;
    for (int i = 0; i < 7; i++) ro_in[i] = 8'h31 + 8'(i * 17);
    repeat (10) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    t_info();
    t_ro();
    t_rw();
    t_hidden();
    t_setpoint();
    t_reset_mid();
    final_report();
  end
endmodule
`default_nettype wire

// *** mrm_host_model.sv ***
/*
  Host controller model: issues mode register read and write commands.
  Assumes mrm_regs on the same core_clk; every command starts 1 ns after an edge.
*/
`timescale 1ns/1ns
`default_nettype none
module mrm_host_model
  import mrm_pkg::*;
(
  // clock
  input wire logic core_clk,
  // command port
  output logic mode_reg_write_cmd,
  output logic mode_reg_read_cmd,
  output mrm_pkg::mrm_addr_t mr_addr_field,
  output mrm_pkg::mrm_data_t wr_opcode,
  // read answer
  input wire logic rd_valid,
  input wire mrm_pkg::mrm_data_t rd_data
);
  initial begin
    mode_reg_write_cmd = 1'b0;
    mode_reg_read_cmd = 1'b0;
    mr_addr_field = 6'h00;
    wr_opcode = 8'h00;
  end

  // reserved opcode bits
  function automatic mrm_data_t wr_mask(input mrm_addr_t a);
    case (a)
      CMD_BUS_VREF_A, DATA_BUS_VREF_A: wr_mask = 8'h7F;
      TERMINATION_CTRL_A: wr_mask = 8'h77;
      IO_CALIBRATION_A: wr_mask = 8'h01;
      default: wr_mask = 8'hFF;
    endcase
  endfunction

  // idle lines flip so a stale value is never taken for a live one
  task automatic release_bus();
    mode_reg_write_cmd = 1'b0;
    mode_reg_read_cmd = 1'b0;
    mr_addr_field = ~mr_addr_field;
    wr_opcode = ~wr_opcode;
  endtask

  task automatic mr_write(input mrm_addr_t a, input mrm_data_t d);
    if ((a >= 6'h1A && a <= 6'h1D) || a == RESERVED_FUTURE_A_A || a >= 6'h30) return;
    @(posedge core_clk);
    #1;
    mr_addr_field = a;
    wr_opcode = d & wr_mask(a);
    mode_reg_write_cmd = 1'b1;
    @(posedge core_clk);
    #1;
    release_bus();
  endtask

  task automatic mr_read(input mrm_addr_t a, output mrm_data_t d, output logic ok);
    @(posedge core_clk);
    #1;
    mr_addr_field = a;
    mode_reg_read_cmd = 1'b1;
    @(posedge core_clk);
    #1;
    release_bus();
    // answer stands from the second edge after the taking edge until the third
    repeat (2) @(posedge core_clk);
    #1;
    ok = rd_valid;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// *** mrm_pkg.sv ***
/*
  Package for the mode register map: addresses, field positions, reset values,
  access classes and readable-bit masks.
  Assumes one core clock domain and a six-bit register address.
*/
package mrm_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 64;

  typedef logic [ADDR_W-1:0] mrm_addr_t;
  typedef logic [DATA_W-1:0] mrm_data_t;

  // access classes
  typedef enum logic [2:0] {
    MRM_ACC_NONE = 3'h0,
    MRM_ACC_RO = 3'h1,
    MRM_ACC_WO = 3'h2,
    MRM_ACC_RW = 3'h3,
    MRM_ACC_TEST = 3'h4
  } mrm_acc_e;

  // register addresses
  localparam mrm_addr_t DEVICE_INFO_A = 6'h00;
  localparam mrm_addr_t DEVICE_FEATURE_ONE_A = 6'h01;
  localparam mrm_addr_t DEVICE_FEATURE_TWO_A = 6'h02;
  localparam mrm_addr_t IO_CONFIG_ONE_A = 6'h03;
  localparam mrm_addr_t REFRESH_AND_TRAINING_A = 6'h04;
  localparam mrm_addr_t MAKER_CODE_A = 6'h05;
  localparam mrm_addr_t REVISION_CODE_ONE_A = 6'h06;
  localparam mrm_addr_t REVISION_CODE_TWO_A = 6'h07;
  localparam mrm_addr_t WIDTH_DENSITY_TYPE_A = 6'h08;
  localparam mrm_addr_t VENDOR_TEST_MODE_A = 6'h09;
  localparam mrm_addr_t IO_CALIBRATION_A = 6'h0A;
  localparam mrm_addr_t TERMINATION_CTRL_A = 6'h0B;
  localparam mrm_addr_t CMD_BUS_VREF_A = 6'h0C;
  localparam mrm_addr_t REGISTER_CONTROL_A = 6'h0D;
  localparam mrm_addr_t DATA_BUS_VREF_A = 6'h0E;
  localparam mrm_addr_t LOWER_BYTE_INVERT_A = 6'h0F;
  localparam mrm_addr_t PARTIAL_REFRESH_BANK_MASK_A = 6'h10;
  localparam mrm_addr_t PARTIAL_REFRESH_SEGMENT_MASK_A = 6'h11;
  localparam mrm_addr_t STROBE_OSC_COUNT_LOW_A = 6'h12;
  localparam mrm_addr_t STROBE_OSC_COUNT_HIGH_A = 6'h13;
  localparam mrm_addr_t UPPER_BYTE_INVERT_A = 6'h14;
  localparam mrm_addr_t VENDOR_USE_A = 6'h15;
  localparam mrm_addr_t TERMINATION_FEATURE_TWO_A = 6'h16;
  localparam mrm_addr_t STROBE_OSC_RUNTIME_A = 6'h17;
  localparam mrm_addr_t ROW_HAMMER_CONTROL_A = 6'h18;
  localparam mrm_addr_t REPAIR_RESOURCES_A = 6'h19;
  localparam mrm_addr_t TEST_RESERVED_A_A = 6'h1E;
  localparam mrm_addr_t RESERVED_FUTURE_A_A = 6'h1F;
  localparam mrm_addr_t CALIB_PATTERN_A_A = 6'h20;
  localparam mrm_addr_t TEST_RESERVED_B_A = 6'h27;
  localparam mrm_addr_t CALIB_PATTERN_B_A = 6'h28;

  // device_info fields
  localparam int INFO_CA_TERM_RANK_FLAG_BIT = 7;
  localparam int INFO_ZQ_HI = 4;
  localparam int INFO_ZQ_LO = 3;
  localparam int INFO_LAT_BIT = 1;
  localparam int INFO_REF_BIT = 0;

  // register_control set point selects
  localparam int SP_OPERATE_BIT = 7;
  localparam int SP_WRITE_BIT = 6;

  // readable-bit masks: reserved bits read zero
  localparam mrm_data_t INFO_RD_MASK = 8'h9B;
  localparam mrm_data_t VREF_RD_MASK = 8'h7F;
  localparam mrm_data_t FULL_RD_MASK = 8'hFF;

  // reset values
  localparam mrm_data_t REG_RESET = 8'h00;
  localparam mrm_data_t VREF_RESET = 8'h5D;
  localparam logic [1:0] ZQ_INFO_RESET = 2'h0;
  // undefined read data is driven as this pattern
  localparam mrm_data_t UNDEF_DATA = 8'h00;

  // per-address classification
  function automatic mrm_acc_e mrm_access(input mrm_addr_t a);
    if (a <= REPAIR_RESOURCES_A) begin
      case (a)
        DEVICE_INFO_A, MAKER_CODE_A, REVISION_CODE_ONE_A, REVISION_CODE_TWO_A,
        WIDTH_DENSITY_TYPE_A, STROBE_OSC_COUNT_LOW_A, STROBE_OSC_COUNT_HIGH_A,
        REPAIR_RESOURCES_A: mrm_access = MRM_ACC_RO;
        REFRESH_AND_TRAINING_A, CMD_BUS_VREF_A, DATA_BUS_VREF_A,
        ROW_HAMMER_CONTROL_A: mrm_access = MRM_ACC_RW;
        default: mrm_access = MRM_ACC_WO;
      endcase
    end else if (a == TEST_RESERVED_A_A || a == TEST_RESERVED_B_A) begin
      mrm_access = MRM_ACC_TEST;
    end else if (a == CALIB_PATTERN_A_A || a == CALIB_PATTERN_B_A) begin
      mrm_access = MRM_ACC_WO;
    end else begin
      mrm_access = MRM_ACC_NONE;
    end
  endfunction

  // registers with two set-point copies
  function automatic logic mrm_dual(input mrm_addr_t a);
    mrm_dual = (a == DEVICE_FEATURE_ONE_A) || (a == DEVICE_FEATURE_TWO_A) ||
               (a == IO_CONFIG_ONE_A) || (a == TERMINATION_CTRL_A) ||
               (a == CMD_BUS_VREF_A) || (a == DATA_BUS_VREF_A) ||
               (a == TERMINATION_FEATURE_TWO_A);
  endfunction
endpackage

// *** mrm_regs.sv ***
/*
  Mode register file: takes register read and write commands, applies the
  access class of each address and keeps set-point copies.
  Assumes commands are single-cycle strobes synchronous to core_clk and that
  the controller zeroes reserved opcode bits and skips reserved addresses.
  // How it works
  // R1 - read command returns addressed register byte
  // R2 - write command updates the addressed register
  // R3 - access class per address is honoured
  // R4 - controller writes reserved bits as zero
  // R5 - reserved bits of readable registers read zero
  // R6 - reserved or write-only reads give undefined
  // R7 - controller never writes future-reserved addresses
  // R8 - writes to read-only registers are discarded
  // R9 - device info bits: rank, ZQ, latency, refresh
  // R10 - write-select picks accessed set-point copy
  // R11 - operate-select picks copy driving operation
  // R12 - ZQ info cleared on reset, set after latch
  // R13 - test and do-not-use writes are ignored
*/
`timescale 1ns/1ns
`default_nettype none
module mrm_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // command port
  input wire logic mode_reg_write_cmd,
  input wire logic mode_reg_read_cmd,
  input wire mrm_pkg::mrm_addr_t mr_addr_field,
  input wire mrm_pkg::mrm_data_t wr_opcode,
  // read answer
  output logic rd_valid,
  output mrm_pkg::mrm_data_t rd_data,
  // device status inputs
  input wire logic ca_term_rank_flag,
  input wire logic latency_mode_cap,
  input wire logic refresh_mode_cap,
  input wire logic zq_latch_done,
  input wire logic [1:0] zq_selftest_result,
  input wire mrm_pkg::mrm_data_t maker_code,
  input wire mrm_pkg::mrm_data_t revision_one,
  input wire mrm_pkg::mrm_data_t revision_two,
  input wire mrm_pkg::mrm_data_t width_density,
  input wire mrm_pkg::mrm_data_t osc_count_low,
  input wire mrm_pkg::mrm_data_t osc_count_high,
  input wire mrm_pkg::mrm_data_t repair_res,
  // operating view
  input wire mrm_pkg::mrm_addr_t op_addr,
  output mrm_pkg::mrm_data_t op_data,
  output logic setpoint_operate_select,
  output logic setpoint_write_select
);
  import mrm_pkg::*;

  typedef enum logic [2:0] {
    MRM_IDLE = 3'b001,
    MRM_READ = 3'b010,
    MRM_HOLD = 3'b100
  } mrm_st_e;

  mrm_st_e st_r, st_nxt;
  logic [1:0] zq_info_r, zq_info_nxt;
  logic sp_op_r, sp_op_nxt;
  logic sp_wr_r, sp_wr_nxt;
  logic [2*NUM_REGS-1:0] written_r, written_nxt;
  mrm_acc_e rd_acc_r, rd_acc_nxt;
  mrm_addr_t rd_addr_r, rd_addr_nxt;
  mrm_data_t rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic rd_wrt_r, rd_wrt_nxt;
  mrm_acc_e wr_acc;
  logic store_wr;
  logic [6:0] store_waddr;
  logic [6:0] store_raddr;
  mrm_data_t store_q;
  mrm_data_t ro_val;
  mrm_data_t rd_mask;

  // copy index: address plus set-point bit for dual registers
  function automatic logic [6:0] slot(input mrm_addr_t a, input logic sp);
    slot = {mrm_dual(a) & sp, a};
  endfunction

  assign wr_acc = mrm_access(mr_addr_field);
  // only writable classes reach storage; RO, test, reserved dropped
  assign store_wr = mode_reg_write_cmd &&
                    (wr_acc == MRM_ACC_WO || wr_acc == MRM_ACC_RW); // [R2] [R3] [R8] [R13]
  assign store_waddr = slot(mr_addr_field, sp_wr_r); // [R10]
  // read port is shared: the command read wins over the operating view
  assign store_raddr = mode_reg_read_cmd ? slot(mr_addr_field, sp_wr_r) :
                       slot(op_addr, sp_op_r); // [R10] [R11]

  mrm_store u_store (
    .core_clk(core_clk),
    .rstn(rstn),
    .wr_en(store_wr),
    .wr_addr(store_waddr),
    .wr_data(wr_opcode),
    .rd_addr(store_raddr),
    .rd_data(store_q)
  );

  // control state
  always_comb begin
    zq_info_nxt = zq_info_r;
    sp_op_nxt = sp_op_r;
    sp_wr_nxt = sp_wr_r;
    written_nxt = written_r;
    if (zq_latch_done) begin
      zq_info_nxt = zq_selftest_result; // [R12]
    end
    if (store_wr) begin
      // each set-point copy tracked apart
      written_nxt[store_waddr] = 1'b1;
      if (mr_addr_field == REGISTER_CONTROL_A) begin
        sp_op_nxt = wr_opcode[SP_OPERATE_BIT]; // [R11]
        sp_wr_nxt = wr_opcode[SP_WRITE_BIT]; // [R10]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      zq_info_r <= ZQ_INFO_RESET; // [R12]
      sp_op_r <= 1'b0;
      sp_wr_r <= 1'b0;
      written_r <= '0;
    end else begin
      zq_info_r <= zq_info_nxt;
      sp_op_r <= sp_op_nxt;
      sp_wr_r <= sp_wr_nxt;
      written_r <= written_nxt;
    end
  end

  // read-only values sampled at the command
  always_comb begin
    ro_val = UNDEF_DATA;
    case (mr_addr_field)
      DEVICE_INFO_A: begin
        ro_val[INFO_CA_TERM_RANK_FLAG_BIT] = ca_term_rank_flag; // [R9]
        ro_val[INFO_ZQ_HI:INFO_ZQ_LO] = zq_info_r; // [R9]
        ro_val[INFO_LAT_BIT] = latency_mode_cap; // [R9]
        ro_val[INFO_REF_BIT] = refresh_mode_cap; // [R9]
      end
      MAKER_CODE_A: ro_val = maker_code;
      REVISION_CODE_ONE_A: ro_val = revision_one;
      REVISION_CODE_TWO_A: ro_val = revision_two;
      WIDTH_DENSITY_TYPE_A: ro_val = width_density;
      STROBE_OSC_COUNT_LOW_A: ro_val = osc_count_low;
      STROBE_OSC_COUNT_HIGH_A: ro_val = osc_count_high;
      REPAIR_RESOURCES_A: ro_val = repair_res;
      default: ro_val = UNDEF_DATA;
    endcase
  end

  // read sequencer: storage read takes one extra cycle
  always_comb begin
    st_nxt = st_r;
    rd_acc_nxt = rd_acc_r;
    rd_addr_nxt = rd_addr_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    rd_wrt_nxt = rd_wrt_r;
    rd_mask = (rd_addr_r == CMD_BUS_VREF_A || rd_addr_r == DATA_BUS_VREF_A) ?
              VREF_RD_MASK : FULL_RD_MASK;
    case (st_r)
      MRM_IDLE: begin
        if (mode_reg_read_cmd) begin // [R1]
          rd_acc_nxt = mrm_access(mr_addr_field);
          rd_addr_nxt = mr_addr_field;
          rd_wrt_nxt = written_r[slot(mr_addr_field, sp_wr_r)];
          rd_data_nxt = ro_val & ((mr_addr_field == DEVICE_INFO_A) ?
                                  INFO_RD_MASK : FULL_RD_MASK); // [R5]
          st_nxt = MRM_READ;
        end
      end
      MRM_READ: begin
        // storage byte stands only now; the op view takes the port back next
        if (rd_acc_r == MRM_ACC_RW) begin
          // never-written RW copies read the reset pattern
          rd_data_nxt = rd_wrt_r ? (store_q & rd_mask) : REG_RESET; // [R5]
        end else if (rd_acc_r != MRM_ACC_RO) begin
          rd_data_nxt = UNDEF_DATA; // [R6]
        end
        st_nxt = MRM_HOLD;
      end
      MRM_HOLD: begin
        rd_valid_nxt = 1'b1;
        st_nxt = MRM_IDLE;
      end
      default: begin
        st_nxt = MRM_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r <= MRM_IDLE;
      rd_acc_r <= MRM_ACC_NONE;
      rd_addr_r <= '0;
      rd_data_r <= REG_RESET;
      rd_valid_r <= 1'b0;
      rd_wrt_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      rd_acc_r <= rd_acc_nxt;
      rd_addr_r <= rd_addr_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_wrt_r <= rd_wrt_nxt;
    end
  end

  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  // operating view lags op_addr by one cycle; in the cycle after a read command it shows the read register instead
  assign op_data = store_q;
  assign setpoint_operate_select = sp_op_r;
  assign setpoint_write_select = sp_wr_r;

  sequence rd_issue_s;
    mode_reg_read_cmd && st_r == MRM_IDLE;
  endsequence

  sequence rd_answer_s;
    ##3 rd_valid;
  endsequence

  read_answer_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R1]
    rd_issue_s |-> rd_answer_s)
    else $error("read answer not on third cycle");

  ro_write_drop_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R8]
    mode_reg_write_cmd && mrm_access(mr_addr_field) == MRM_ACC_RO |-> !store_wr)
    else $error("write reached read-only register");

  test_write_drop_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R13]
    mode_reg_write_cmd && mrm_access(mr_addr_field) inside {MRM_ACC_TEST, MRM_ACC_NONE}
    |=> $stable(written_r) && $stable(sp_op_r))
    else $error("ignored address changed state");

  info_rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R5]
    rd_valid && rd_acc_r == MRM_ACC_RO && rd_addr_r == DEVICE_INFO_A |->
    (rd_data & ~INFO_RD_MASK) == 8'h00)
    else $error("reserved info bit not zero");

  info_zq_field_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R9]
    (rd_issue_s and (mr_addr_field == DEVICE_INFO_A)) |->
    ##3 rd_data[INFO_ZQ_HI:INFO_ZQ_LO] == $past(zq_info_r, 3))
    else $error("info ZQ field wrong");

  zq_reset_clear_a: assert property (@(posedge core_clk) // [R12]
    !rstn |=> zq_info_r == ZQ_INFO_RESET)
    else $error("ZQ info not cleared by reset");

  sp_select_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R10]
    store_wr && mrm_dual(mr_addr_field) |-> store_waddr[6] == sp_wr_r)
    else $error("write went to wrong set point");

  sp_operate_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R11]
    store_wr && mr_addr_field == REGISTER_CONTROL_A |=>
    setpoint_operate_select == $past(wr_opcode[SP_OPERATE_BIT]))
    else $error("operate select not updated");

  wo_read_undef_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R6]
    rd_valid && rd_acc_r inside {MRM_ACC_WO, MRM_ACC_NONE, MRM_ACC_TEST} |->
    rd_data == UNDEF_DATA)
    else $error("write-only read not fixed pattern");

  rd_valid_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R1]
    rd_valid |=> !rd_valid)
    else $error("read valid longer than one cycle");

  rd_data_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R1]
    st_r == MRM_IDLE && !mode_reg_read_cmd |=> $stable(rd_data))
    else $error("read data moved without a read");

  rw_vref_msb_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R5]
    rd_valid && rd_acc_r == MRM_ACC_RW &&
    (rd_addr_r == CMD_BUS_VREF_A || rd_addr_r == DATA_BUS_VREF_A) |->
    (rd_data & ~VREF_RD_MASK) == 8'h00)
    else $error("reserved reference bit not zero");

  info_flags_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R9]
    rd_valid && rd_acc_r == MRM_ACC_RO && rd_addr_r == DEVICE_INFO_A |->
    rd_data[INFO_CA_TERM_RANK_FLAG_BIT] == $past(ca_term_rank_flag, 3) &&
    rd_data[INFO_LAT_BIT] == $past(latency_mode_cap, 3) &&
    rd_data[INFO_REF_BIT] == $past(refresh_mode_cap, 3))
    else $error("info capability bits wrong");

  zq_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R12]
    !zq_latch_done |=> $stable(zq_info_r))
    else $error("ZQ info moved without a latch");

  sp_write_update_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R10]
    store_wr && mr_addr_field == REGISTER_CONTROL_A |=>
    setpoint_write_select == $past(wr_opcode[SP_WRITE_BIT]))
    else $error("write select not updated");

  sp_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R11]
    !(store_wr && mr_addr_field == REGISTER_CONTROL_A) |=>
    $stable(sp_op_r) && $stable(sp_wr_r))
    else $error("set point selects moved without a write");
endmodule
`default_nettype wire

// *** mrm_store.sv ***
/*
  Small register memory: 128 words of 8 bits, one write port,
  one registered read port.
  Assumes synchronous inputs on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module mrm_store (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // write port
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data
);
  import mrm_pkg::*;
  logic [7:0] mem_r [0:127];
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;

  always_comb begin
    rd_data_nxt = mem_r[rd_addr];
  end

  // memory holds no reset; owner keeps valid bits elsewhere
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_data_r <= REG_RESET;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;
endmodule
`default_nettype wire
